// file: ptg_timer.sv
`timescale 1ns/1ns
module ptg_timer
  import ptg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ptg_pkg::PTG_ADDR_W-1:0] paddr,
  input wire logic [ptg_pkg::PTG_DATA_W-1:0] pwdata,
  output logic [ptg_pkg::PTG_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_clock,
  input wire logic ext_gate_reset_in,
  output logic postscaled_pulse,
  output logic pwm_out,
  output logic irq
);

  ptg_tick_if tk();

  ptg_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .timer_input_clock(timer_input_clock),
    .ext_gate_reset_in(ext_gate_reset_in),
    .tk(tk.gen)
  );

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == PTG_OFF_CTRL) || (a == PTG_OFF_PERIOD) || (a == PTG_OFF_COUNT)
      || (a == PTG_OFF_DUTY) || (a == PTG_OFF_STATUS) || (a == PTG_OFF_IRQ_EN)
      || (a == PTG_OFF_IRQ_CLR);
  endfunction : addr_known

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, so pready and prdata both come from flops

  logic [31:0] ctrl_q, ctrl_d;
  logic [7:0] period_q, period_d;
  logic [7:0] duty_q, duty_d;
  logic [PTG_ST_W-1:0] irq_en_q, irq_en_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic wr_en;
  logic [PTG_ST_W-1:0] clr_bits;
  logic [PTG_ST_W-1:0] status_q, status_d;
  logic [7:0] count_q, count_d;

  always_comb begin
    pready_d = psel & penable & ~pready_q;
    pslverr_d = psel & penable & ~pready_q & ~addr_known(paddr);
    wr_en = psel & penable & pready_q & pwrite & addr_known(paddr);
    ctrl_d = ctrl_q;
    period_d = period_q;
    duty_d = duty_q;
    irq_en_d = irq_en_q;
    clr_bits = '0;
    prdata_d = prdata_q;
    if (wr_en) begin
      case (paddr)
        PTG_OFF_CTRL: ctrl_d = pwdata;
        PTG_OFF_PERIOD: period_d = pwdata[7:0];
        PTG_OFF_DUTY: duty_d = pwdata[7:0];
        PTG_OFF_IRQ_EN: irq_en_d = pwdata[PTG_ST_W-1:0];
        PTG_OFF_IRQ_CLR: clr_bits = pwdata[PTG_ST_W-1:0];
        default: ;
      endcase
    end
    if (psel & penable & ~pready_q) begin
      case (paddr)
        PTG_OFF_CTRL: prdata_d = ctrl_q;
        PTG_OFF_PERIOD: prdata_d = {24'h00_0000, period_q};
        PTG_OFF_COUNT: prdata_d = {24'h00_0000, count_q};
        PTG_OFF_DUTY: prdata_d = {24'h00_0000, duty_q};
        PTG_OFF_STATUS: prdata_d = {30'h0000_0000, status_q};
        PTG_OFF_IRQ_EN: prdata_d = {30'h0000_0000, irq_en_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= PTG_CTRL_RST;
      period_q <= PTG_PERIOD_RST;
      duty_q <= PTG_DUTY_RST;
      irq_en_q <= '0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      period_q <= period_d;
      duty_q <= duty_d;
      irq_en_q <= irq_en_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Timer core

  logic [4:0] mode;
  logic [3:0] post_sel;
  logic gate_ok, counting, match, post_hit;
  logic [3:0] post_q, post_d;
  logic postscaled_q, postscaled_d;
  logic pwm_q, pwm_d;

  assign mode = ctrl_q[PTG_CTRL_MODE_LSB +: 5];
  assign post_sel = ctrl_q[PTG_CTRL_POST_LSB +: 4];
  assign tk.use_ext = ctrl_q[PTG_CTRL_EXTCLK];
  assign tk.prescale_select = ctrl_q[PTG_CTRL_PRE_LSB +: 3];
  assign tk.run_req = ctrl_q[PTG_CTRL_RUN];

  always_comb begin
    case (mode)
      PTG_MODE_SW_GATE: gate_ok = 1'b1;
      PTG_MODE_HW_GATE_A: gate_ok = tk.gate_eff;
      PTG_MODE_HW_GATE_B: gate_ok = tk.gate_eff;
      default: gate_ok = 1'b0;
    endcase
    counting = tk.cnt_tick & tk.run_eff & gate_ok;
    match = counting & (count_q == period_q);
    post_hit = match & (post_q >= post_sel);
    count_d = count_q;
    post_d = post_q;
    if (match) begin
      count_d = 8'h00;
      post_d = post_hit ? 4'h0 : post_q + 4'h1;
    end else if (counting) begin
      count_d = count_q + 8'h01;
    end
    postscaled_d = post_hit;
    // Held count holds the output, stretching period and whichever phase the hold lands in
    pwm_d = (count_q < duty_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 8'h00;
      post_q <= 4'h0;
      postscaled_q <= 1'b0;
      pwm_q <= 1'b0;
    end else begin
      count_q <= count_d;
      post_q <= post_d;
      postscaled_q <= postscaled_d;
      pwm_q <= pwm_d;
    end
  end

  assign postscaled_pulse = postscaled_q;
  assign pwm_out = pwm_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: hardware set wins over a same-cycle clear

  logic match_q;
  logic irq_q, irq_d;

  always_comb begin
    status_d = status_q & ~clr_bits;
    status_d[PTG_ST_POST] = status_d[PTG_ST_POST] | postscaled_q;
    status_d[PTG_ST_MATCH] = status_d[PTG_ST_MATCH] | match_q;
    irq_d = |(status_q & irq_en_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
      match_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      match_q <= match;
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Counter and gating
  AST_WRAP: assert property (counting && count_q == period_q |=> count_q == 8'h00)
    else $error("count did not wrap after period match");
  AST_INC: assert property (counting && count_q != period_q
      |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not advance on timer clock");
  AST_HOLD_STOP: assert property (!tk.run_eff |=> $stable(count_q))
    else $error("count moved while stopped");
  AST_SW_GATE: assert property (mode == PTG_MODE_SW_GATE && tk.cnt_tick && tk.run_eff
      && count_q != period_q |=> count_q != $past(count_q))
    else $error("software gate ignored run bit");
  AST_SW_NO_GATE: assert property (mode == PTG_MODE_SW_GATE && tk.cnt_tick && tk.run_eff
      && !tk.gate_eff && count_q != period_q |=> count_q == $past(count_q) + 8'h01)
    else $error("software gate mode obeyed the gate input");
  AST_GATE_A: assert property (mode == PTG_MODE_HW_GATE_A && !tk.gate_eff
      |=> $stable(count_q))
    else $error("count moved with gate low");
  AST_RUN_A: assert property (mode == PTG_MODE_HW_GATE_A && tk.cnt_tick && tk.run_eff
      && tk.gate_eff && count_q != period_q |=> count_q == $past(count_q) + 8'h01)
    else $error("count held with run and gate both high");
  AST_GATE_B: assert property (mode == PTG_MODE_HW_GATE_B && !tk.gate_eff
      |=> $stable(count_q))
    else $error("count moved with gate low");
  AST_RUN_B: assert property (mode == PTG_MODE_HW_GATE_B && tk.cnt_tick && tk.run_eff
      && tk.gate_eff && count_q != period_q |=> count_q == $past(count_q) + 8'h01)
    else $error("count held with gate high");
  // Undecoded modes hold rather than guess at a behaviour nobody asked for
  AST_OTHER_MODE: assert property (mode != PTG_MODE_SW_GATE && mode != PTG_MODE_HW_GATE_A
      && mode != PTG_MODE_HW_GATE_B |=> $stable(count_q))
    else $error("count moved in an undecoded mode");

  // Postscaler, flags and interrupt
  AST_POST: assert property (match && post_q >= post_sel |=> postscaled_q && post_q == 4'h0)
    else $error("postscaler missed its ratio");
  AST_POST_EARLY: assert property (match && post_q < post_sel
      |=> !postscaled_q && post_q == $past(post_q) + 4'h1)
    else $error("postscaler fired before its ratio");
  AST_POST_IDLE: assert property (!match |=> post_q == $past(post_q))
    else $error("postscaler moved without a wrap");
  AST_POST_PULSE: assert property (postscaled_q |=> !postscaled_q)
    else $error("postscaled pulse longer than one cycle");
  AST_FLAG: assert property (postscaled_q |=> status_q[PTG_ST_POST])
    else $error("flag not set after postscaled event");
  AST_MATCH_FLAG: assert property (match_q |=> status_q[PTG_ST_MATCH])
    else $error("match flag not set after wrap");
  AST_STICKY: assert property (status_q[PTG_ST_POST] && !clr_bits[PTG_ST_POST]
      |=> status_q[PTG_ST_POST])
    else $error("flag dropped without clear");
  AST_CLR: assert property (clr_bits[PTG_ST_POST] && !postscaled_q
      |=> !status_q[PTG_ST_POST])
    else $error("flag not cleared by software");
  AST_CLR_MATCH: assert property (clr_bits[PTG_ST_MATCH] && !match_q
      |=> !status_q[PTG_ST_MATCH])
    else $error("match flag not cleared by software");
  AST_IRQ: assert property (status_q[PTG_ST_POST] && irq_en_q[PTG_ST_POST] |=> irq_q)
    else $error("enabled flag did not raise irq");
  AST_IRQ_MASK: assert property (!(|(status_q & irq_en_q)) |=> !irq_q)
    else $error("irq high with nothing enabled");

  // Modulator output
  AST_PWM_HIGH: assert property (count_q < duty_q |=> pwm_q)
    else $error("modulator output low below duty");
  AST_PWM_LOW: assert property (count_q >= duty_q |=> !pwm_q)
    else $error("modulator output high at or above duty");
  AST_PWM_HOLD: assert property (!counting && !wr_en ##1 !counting && !wr_en
      |=> $stable(pwm_q))
    else $error("modulator output moved while held");

  // Register bus
  AST_READY_PULSE: assert property (pready_q |=> !pready_q)
    else $error("pready stood for more than one cycle");
  AST_ERR_READY: assert property (pslverr_q |-> pready_q)
    else $error("pslverr without pready");
  AST_UNMAPPED: assert property (psel && penable && !pready_q && !addr_known(paddr)
      |=> prdata_q == 32'h0000_0000 && pslverr_q)
    else $error("unmapped access not refused");
  AST_WR_PERIOD: assert property (wr_en && paddr == PTG_OFF_PERIOD
      |=> period_q == $past(pwdata[7:0]))
    else $error("period write did not land");

  COV_WRAP: cover property (match);
  COV_POST: cover property (postscaled_q);
  COV_IRQ: cover property ($rose(irq_q));
  COV_GATED: cover property (mode == PTG_MODE_HW_GATE_A && tk.run_eff && !tk.gate_eff);
  COV_SET_CLR: cover property (postscaled_q && clr_bits[PTG_ST_POST]);

endmodule : ptg_timer

// file: ptg_pkg.sv
package ptg_pkg;

  localparam int unsigned PTG_ADDR_W = 8;
  localparam int unsigned PTG_DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] PTG_OFF_CTRL = 8'h00;
  localparam logic [7:0] PTG_OFF_PERIOD = 8'h04;
  localparam logic [7:0] PTG_OFF_COUNT = 8'h08;
  localparam logic [7:0] PTG_OFF_DUTY = 8'h0c;
  localparam logic [7:0] PTG_OFF_STATUS = 8'h10;
  localparam logic [7:0] PTG_OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] PTG_OFF_IRQ_CLR = 8'h18;

  // Control register field positions
  localparam int unsigned PTG_CTRL_RUN = 0;
  localparam int unsigned PTG_CTRL_PRE_LSB = 1;
  localparam int unsigned PTG_CTRL_POST_LSB = 4;
  localparam int unsigned PTG_CTRL_MODE_LSB = 8;
  localparam int unsigned PTG_CTRL_EXTCLK = 16;

  // Status / enable / clear bit positions
  localparam int unsigned PTG_ST_POST = 0;
  localparam int unsigned PTG_ST_MATCH = 1;
  localparam int unsigned PTG_ST_W = 2;

  // Reset values
  localparam logic [31:0] PTG_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] PTG_PERIOD_RST = 8'hff;
  localparam logic [7:0] PTG_DUTY_RST = 8'h00;

  // Gate modes
  localparam logic [4:0] PTG_MODE_SW_GATE = 5'h00;
  localparam logic [4:0] PTG_MODE_HW_GATE_A = 5'h01;
  localparam logic [4:0] PTG_MODE_HW_GATE_B = 5'h02;

  // Instruction clock: one enable pulse per four pclk cycles
  localparam int unsigned PTG_INSTR_DIV = 4;
  localparam logic [1:0] PTG_INSTR_LAST = 2'(PTG_INSTR_DIV - 1);

endpackage : ptg_pkg

// file: ptg_tick_if.sv
`timescale 1ns/1ns
interface ptg_tick_if;
  logic use_ext;
  logic [2:0] prescale_select;
  logic run_req;
  logic run_eff;
  logic gate_eff;
  logic cnt_tick;

  modport core (
    output use_ext,
    output prescale_select,
    output run_req,
    input run_eff,
    input gate_eff,
    input cnt_tick
  );

  modport gen (
    input use_ext,
    input prescale_select,
    input run_req,
    output run_eff,
    output gate_eff,
    output cnt_tick
  );
endinterface : ptg_tick_if

// file: ptg_tick_gen.sv
`timescale 1ns/1ns
module ptg_tick_gen
  import ptg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic timer_input_clock,
  input wire logic ext_gate_reset_in,
  ptg_tick_if.gen tk
);

  function automatic logic [6:0] pre_limit(input logic [2:0] sel);
    pre_limit = 7'((8'h01 << sel) - 8'h01);
  endfunction : pre_limit

  logic [1:0] div_q, div_d;
  logic tin_s1_q, tin_s2_q, tin_s3_q;
  logic run_p1_q, run_p1_d, run_p2_q, run_p2_d;
  logic gate_p1_q, gate_p1_d, gate_p2_q, gate_p2_d;
  logic [6:0] pre_q, pre_d;
  logic tick_q, tick_d;
  logic instr_tick, src_tick;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    instr_tick = (div_q == PTG_INSTR_LAST);
    div_d = div_q + 2'h1;
    // First sync stage feeds only the second
    src_tick = tk.use_ext ? (tin_s2_q & ~tin_s3_q) : instr_tick;
    run_p1_d = run_p1_q;
    run_p2_d = run_p2_q;
    gate_p1_d = gate_p1_q;
    gate_p2_d = gate_p2_q;
    pre_d = pre_q;
    tick_d = 1'b0;
    if (src_tick) begin
      run_p1_d = tk.run_req;
      run_p2_d = run_p1_q;
      gate_p1_d = ext_gate_reset_in;
      gate_p2_d = gate_p1_q;
      if (pre_q >= pre_limit(tk.prescale_select)) begin
        pre_d = 7'h00;
        tick_d = 1'b1;
      end else begin
        pre_d = pre_q + 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
      tin_s1_q <= 1'b0;
      tin_s2_q <= 1'b0;
      tin_s3_q <= 1'b0;
      run_p1_q <= 1'b0;
      run_p2_q <= 1'b0;
      gate_p1_q <= 1'b0;
      gate_p2_q <= 1'b0;
      pre_q <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tin_s1_q <= timer_input_clock;
      tin_s2_q <= tin_s1_q;
      tin_s3_q <= tin_s2_q;
      run_p1_q <= run_p1_d;
      run_p2_q <= run_p2_d;
      gate_p1_q <= gate_p1_d;
      gate_p2_q <= gate_p2_d;
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end

  // Instruction clock gets one stage, the external source two stages, each advanced on a source edge
  assign tk.run_eff = tk.use_ext ? run_p2_q : run_p1_q;
  assign tk.gate_eff = tk.use_ext ? gate_p2_q : gate_p1_q;
  assign tk.cnt_tick = tick_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RUN_INSTR: assert property (!tk.use_ext && instr_tick |=> run_p1_q == $past(tk.run_req))
    else $error("run bit not taken at instruction period");
  AST_GATE_INSTR: assert property (!tk.use_ext && instr_tick
      |=> gate_p1_q == $past(ext_gate_reset_in))
    else $error("gate not sampled at instruction period");
  AST_RUN_EXT: assert property (tk.use_ext && src_tick |=> run_p2_q == $past(run_p1_q))
    else $error("run bit skipped a sync stage");

endmodule : ptg_tick_gen

// file: ptg_far_side.sv
`timescale 1ns/1ns
module ptg_far_side (
  input wire logic pclk,
  input wire logic postscaled_pulse,
  input wire logic pwm_out,
  output logic timer_input_clock,
  output logic ext_gate_reset_in
);
  int pulse_cnt = 0;
  int pwm_high_cnt = 0;

  initial begin
    timer_input_clock = 1'b0;
    ext_gate_reset_in = 1'b0;
  end

  // Consumer side: tallies postscaled events and modulator high time
  always @(posedge pclk) begin
    if (postscaled_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
    if (pwm_out === 1'b1) pwm_high_cnt <= pwm_high_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate level is held for long stretches so the sync stages always see it
  task automatic set_gate(input logic v);
    @(posedge pclk);
    ext_gate_reset_in <= v;
  endtask : set_gate

  // Source clock only toggles inside a burst and rests low afterwards
  task automatic src_edges(input int n);
    repeat (n) begin
      repeat (5) @(posedge pclk);
      timer_input_clock <= 1'b1;
      repeat (5) @(posedge pclk);
      timer_input_clock <= 1'b0;
    end
  endtask : src_edges
endmodule : ptg_far_side

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import ptg_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, timer_input_clock, ext_gate_reset_in;
  logic postscaled_pulse, pwm_out, irq;
  int n_errors = 0;
  int cmp_count = 0;

  always #5 pclk = ~pclk;

  ptg_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_input_clock(timer_input_clock),
    .ext_gate_reset_in(ext_gate_reset_in), .postscaled_pulse(postscaled_pulse),
    .pwm_out(pwm_out), .irq(irq));

  ptg_far_side i_far (.pclk(pclk), .postscaled_pulse(postscaled_pulse), .pwm_out(pwm_out),
    .timer_input_clock(timer_input_clock), .ext_gate_reset_in(ext_gate_reset_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask : rd

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      n_errors++;
    end
  endtask : chk_rng

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    logic e;
    rd(PTG_OFF_CTRL, d);
    chk("ctrl", PTG_CTRL_RST, d);
    rd(PTG_OFF_PERIOD, d);
    chk("period", {24'h0, PTG_PERIOD_RST}, d);
    apb(1'b0, 8'h40, 32'h0, d, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    wr(PTG_OFF_COUNT, 32'h0000_0055);
    rd(PTG_OFF_COUNT, d);
    chk("count ro", 32'h0, d);
  endtask : t_reset

  task automatic t_swgate();
    logic [31:0] c1, c2;
    int p0, top;
    top = 0;
    wr(PTG_OFF_PERIOD, 32'h0000_0005);
    wr(PTG_OFF_CTRL, 32'h0000_0001);
    p0 = i_far.pulse_cnt;
    repeat (24) begin
      rd(PTG_OFF_COUNT, c1);
      if (int'(c1) > top) top = int'(c1);
    end
    chk_rng("wrap top", 5, 5, top);
    chk_rng("pulses", 3, 4, i_far.pulse_cnt - p0);
    wr(PTG_OFF_CTRL, 32'h0);
    repeat (8) @(posedge pclk);
    rd(PTG_OFF_COUNT, c1);
    repeat (40) @(posedge pclk);
    rd(PTG_OFF_COUNT, c2);
    chk("hold", c1, c2);
  endtask : t_swgate

  task automatic t_irq();
    logic [31:0] d;
    int p0;
    wr(PTG_OFF_PERIOD, 32'h0000_0001);
    wr(PTG_OFF_IRQ_EN, 32'h0000_0001);
    p0 = i_far.pulse_cnt;
    wr(PTG_OFF_CTRL, 32'h0000_0021);
    repeat (240) @(posedge pclk);
    chk_rng("post ratio", 9, 11, i_far.pulse_cnt - p0);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(PTG_OFF_CTRL, 32'h0);
    repeat (12) @(posedge pclk);
    wr(PTG_OFF_IRQ_CLR, 32'h0000_0003);
    rd(PTG_OFF_STATUS, d);
    chk("status clr", 32'h0, d);
    chk("irq off", 32'h0, {31'h0, irq});
    wr(PTG_OFF_IRQ_EN, 32'h0);
    wr(PTG_OFF_CTRL, 32'h0000_0021);
    repeat (60) @(posedge pclk);
    wr(PTG_OFF_CTRL, 32'h0);
    repeat (12) @(posedge pclk);
    rd(PTG_OFF_STATUS, d);
    chk("sticky", 32'h1, d & 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
  endtask : t_irq

  task automatic t_pwm();
    int h0, p0;
    wr(PTG_OFF_PERIOD, 32'h0000_0005);
    wr(PTG_OFF_DUTY, 32'h0000_0003);
    i_far.set_gate(1'b1);
    wr(PTG_OFF_CTRL, 32'h0000_0101);
    repeat (30) @(posedge pclk);
    h0 = i_far.pwm_high_cnt;
    repeat (96) @(posedge pclk);
    chk_rng("pwm high time", 47, 49, i_far.pwm_high_cnt - h0);
    // Stop just after the output rises so the hold lands inside the high phase
    do begin
      @(posedge pclk);
    end while (pwm_out !== 1'b0);
    do begin
      @(posedge pclk);
    end while (pwm_out !== 1'b1);
    i_far.set_gate(1'b0);
    repeat (8) @(posedge pclk);
    h0 = i_far.pwm_high_cnt;
    p0 = i_far.pulse_cnt;
    repeat (40) @(posedge pclk);
    chk_rng("pwm held high", 40, 40, i_far.pwm_high_cnt - h0);
    chk_rng("held period wraps", 0, 0, i_far.pulse_cnt - p0);
    i_far.set_gate(1'b1);
    wr(PTG_OFF_CTRL, 32'h0);
    wr(PTG_OFF_DUTY, 32'h0);
  endtask : t_pwm

  task automatic t_gate();
    logic [31:0] c1, c2;
    wr(PTG_OFF_PERIOD, 32'h0000_00ff);
    for (int m = 1; m <= 2; m++) begin
      i_far.set_gate(1'b0);
      wr(PTG_OFF_CTRL, 32'h1 | (32'(m) << PTG_CTRL_MODE_LSB));
      repeat (12) @(posedge pclk);
      rd(PTG_OFF_COUNT, c1);
      repeat (40) @(posedge pclk);
      rd(PTG_OFF_COUNT, c2);
      chk("gate low hold", c1, c2);
      i_far.set_gate(1'b1);
      repeat (12) @(posedge pclk);
      rd(PTG_OFF_COUNT, c1);
      repeat (40) @(posedge pclk);
      rd(PTG_OFF_COUNT, c2);
      chk_rng("gate high run", 10, 12, int'((c2 - c1) & 32'hff));
      wr(PTG_OFF_CTRL, 32'h0);
    end
    wr(PTG_OFF_CTRL, 32'h0000_0301);
    repeat (12) @(posedge pclk);
    rd(PTG_OFF_COUNT, c1);
    repeat (40) @(posedge pclk);
    rd(PTG_OFF_COUNT, c2);
    chk("undecoded mode hold", c1, c2);
    wr(PTG_OFF_CTRL, 32'h0);
  endtask : t_gate

  task automatic t_ext();
    logic [31:0] c1, c2;
    wr(PTG_OFF_PERIOD, 32'h0000_00ff);
    wr(PTG_OFF_CTRL, 32'h0001_0002);
    rd(PTG_OFF_COUNT, c1);
    wr(PTG_OFF_CTRL, 32'h0001_0003);
    i_far.src_edges(20);
    rd(PTG_OFF_COUNT, c2);
    chk_rng("prescaled", 7, 10, int'((c2 - c1) & 32'hff));
    wr(PTG_OFF_CTRL, 32'h0001_0002);
    i_far.src_edges(4);
    rd(PTG_OFF_COUNT, c1);
    i_far.src_edges(10);
    rd(PTG_OFF_COUNT, c2);
    chk("ext stop", c1, c2);
  endtask : t_ext

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_swgate();
    t_irq();
    t_pwm();
    t_gate();
    t_ext();
    print_verdict();
  end

  // Whole sequence needs well under two thousand cycles; this bound is generous
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end
endmodule : tb_top
